// ==== design/jump_timing_pkg.sv ====
// package: jump decode encodings, target kinds and cycle counts
package jump_timing_pkg;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [7:0] OPC_GROUP5   = 8'h0_0ff;
  localparam logic [7:0] OPC_FAR_DIR  = 8'h0_0ea;
  localparam logic [2:0] REG_JMP_NEAR = 3'h0_4;
  localparam logic [2:0] REG_JMP_FAR  = 3'h0_5;
  localparam logic [1:0] MOD_REGISTER = 2'h0_3;
  localparam int         MODRM_REG_HI = 5;
  localparam int         MODRM_REG_LO = 3;
  localparam int         MODRM_MOD_HI = 7;
  localparam int         MODRM_MOD_LO = 6;

  // ****************************************************************
  // far jump target kinds, resolved by descriptor logic elsewhere
  // ****************************************************************
  typedef enum logic [2:0] {
    TGT_SEGMENT   = 3'h0_0,
    TGT_CALL_GATE = 3'h0_1,
    TGT_TSS16     = 3'h0_2,
    TGT_TSS32     = 3'h0_3,
    TGT_V86_TASK  = 3'h0_4
  } target_kind_t;

  typedef enum logic [2:0] {
    FORM_NONE     = 3'h0_0,
    FORM_NEAR_REG = 3'h0_1,
    FORM_NEAR_MEM = 3'h0_2,
    FORM_FAR_DIR  = 3'h0_3,
    FORM_FAR_IND  = 3'h0_4
  } jump_form_t;

  // ****************************************************************
  // base cycle counts (m is added where the count carries it)
  // ****************************************************************
  localparam logic [8:0] CYC_NEAR_REG        = 9'h0_007;
  localparam logic [8:0] CYC_NEAR_MEM        = 9'h0_00a;
  localparam logic [8:0] CYC_FAR_DIR_REAL    = 9'h0_00c;
  localparam logic [8:0] CYC_FAR_DIR_PROT    = 9'h0_01b;
  localparam logic [8:0] CYC_FAR_IND_PROT    = 9'h0_01f;
  localparam logic [8:0] CYC_GATE_DIR        = 9'h0_02d;
  localparam logic [8:0] CYC_GATE_IND        = 9'h0_031;
  localparam logic [8:0] CYC_DIR_T16_TSS16   = 9'h0_112;
  localparam logic [8:0] CYC_DIR_T16_TSS32   = 9'h0_12d;
  localparam logic [8:0] CYC_DIR_T16_V86     = 9'h0_0db;
  localparam logic [8:0] CYC_DIR_T32_TSS16   = 9'h0_10e;
  localparam logic [8:0] CYC_DIR_T32_TSS32   = 9'h0_12f;
  localparam logic [8:0] CYC_DIR_T32_V86     = 9'h0_0dd;
  localparam logic [8:0] CYC_IND_T16_TSS16   = 9'h0_117;
  localparam logic [8:0] CYC_IND_T16_TSS32   = 9'h0_132;
  localparam logic [8:0] CYC_IND_T16_V86     = 9'h0_0df;
  // indirect far jump from a 32-bit task is not given: reuse the 32-bit direct counts
  localparam logic [8:0] CYC_COUNT_RESET     = 9'h0_000;

endpackage

// ==== design/jump_cycle_if.sv ====
// interface: load strobe and cycle budget from decoder to counter, busy and done back
`timescale 1ns/10ps
`default_nettype none
interface jump_cycle_if;
  logic       load;
  logic [8:0] budget;
  logic       busy;
  logic       done;
  modport decoder (output load, output budget, input busy, input done);
  modport counter (input load, input budget, output busy, output done);
endinterface
`default_nettype wire

// ==== design/jump_cycle_counter.sv ====
// module: counts out a cycle budget and pulses done on its last cycle
`timescale 1ns/10ps
`default_nettype none
module jump_cycle_counter (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // budget hand-off
  jump_cycle_if.counter cyc
);

  logic [8:0] remain_r;
  logic [8:0] remain_nxt;

  always_comb begin
    remain_nxt = remain_r;
    if (cyc.load) begin
      remain_nxt = cyc.budget;
    end else if (remain_r != jump_timing_pkg::CYC_COUNT_RESET) begin
      remain_nxt = remain_r - 9'h0_001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      remain_r <= jump_timing_pkg::CYC_COUNT_RESET;
    end else if (clk_en) begin
      remain_r <= remain_nxt;
    end
  end

  assign cyc.busy = (remain_r != jump_timing_pkg::CYC_COUNT_RESET);
  assign cyc.done = (remain_r == 9'h0_001);

endmodule
`default_nettype wire

// ==== design/jump_decode_cycle_timing.sv ====
// module: unconditional jump decoder and cycle-count sequencer
// Function
// [RQ1] opcode ff, reg 100: near indirect jump, 7+m register, 10+m memory
// [RQ2] opcode ea with offset and selector: far direct, 12+m real/v86, 27+m protected
// [RQ3] opcode ff, reg 101: far indirect through memory, 31+m protected
// [RQ4] call gate same privilege: 45+m direct, 49+m indirect
// [RQ5] direct from 16-bit task: 274, 301, 219 cycles by target
// [RQ6] direct from 32-bit task: 270, 303, 221 cycles by target
// [RQ7] indirect from 16-bit task: 279, 306, 223 cycles by target
// [RQ8] m is next instruction component count, added to base count
`timescale 1ns/10ps
`default_nettype none
module jump_decode_cycle_timing (
  // clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // instruction presented for decode
  input  wire logic       instr_valid,
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] modrm,
  input  wire logic       prot_mode,
  input  wire logic       v86_mode,
  input  wire logic       task_is_32,
  input  wire logic [2:0] target_kind,
  input  wire logic [3:0] next_components,
  // decode result and timing
  output logic            instr_ready,
  output logic            is_jump,
  output logic [2:0]      jump_form,
  output logic [8:0]      cycle_count,
  output logic            busy,
  output logic            done
);

  // ****************************************************************
  // decode
  // ****************************************************************
  jump_timing_pkg::jump_form_t form_c;
  logic [8:0]                  base_c;
  logic                        add_m_c;
  logic [2:0]                  reg_fld;
  logic                        prot_eff;
  jump_timing_pkg::target_kind_t tk;

  assign reg_fld  = modrm[jump_timing_pkg::MODRM_REG_HI:jump_timing_pkg::MODRM_REG_LO];
  // virtual-8086 code runs on real-mode timing
  assign prot_eff = prot_mode && !v86_mode;
  assign tk       = jump_timing_pkg::target_kind_t'(target_kind);

  always_comb begin
    form_c = jump_timing_pkg::FORM_NONE;
    if (opcode == jump_timing_pkg::OPC_FAR_DIR) begin
      form_c = jump_timing_pkg::FORM_FAR_DIR; // RQ2
    end else if (opcode == jump_timing_pkg::OPC_GROUP5) begin
      if (reg_fld == jump_timing_pkg::REG_JMP_NEAR) begin
        if (modrm[jump_timing_pkg::MODRM_MOD_HI:jump_timing_pkg::MODRM_MOD_LO]
            == jump_timing_pkg::MOD_REGISTER) begin
          form_c = jump_timing_pkg::FORM_NEAR_REG; // RQ1
        end else begin
          form_c = jump_timing_pkg::FORM_NEAR_MEM; // RQ1
        end
      end else if (reg_fld == jump_timing_pkg::REG_JMP_FAR) begin
        form_c = jump_timing_pkg::FORM_FAR_IND; // RQ3
      end
    end
  end

  // ****************************************************************
  // base count selection
  // ****************************************************************
  always_comb begin
    base_c  = jump_timing_pkg::CYC_COUNT_RESET;
    add_m_c = 1'b1;
    unique case (form_c)
      jump_timing_pkg::FORM_NEAR_REG: begin
        base_c = jump_timing_pkg::CYC_NEAR_REG; // RQ1
      end
      jump_timing_pkg::FORM_NEAR_MEM: begin
        base_c = jump_timing_pkg::CYC_NEAR_MEM; // RQ1
      end
      jump_timing_pkg::FORM_FAR_DIR: begin
        if (!prot_eff) begin
          base_c = jump_timing_pkg::CYC_FAR_DIR_REAL; // RQ2
        end else begin
          unique case (tk)
            jump_timing_pkg::TGT_SEGMENT:   base_c = jump_timing_pkg::CYC_FAR_DIR_PROT; // RQ2
            jump_timing_pkg::TGT_CALL_GATE: base_c = jump_timing_pkg::CYC_GATE_DIR; // RQ4
            jump_timing_pkg::TGT_TSS16: begin
              add_m_c = 1'b0;
              if (task_is_32) begin
                base_c = jump_timing_pkg::CYC_DIR_T32_TSS16; // RQ6
              end else begin
                base_c = jump_timing_pkg::CYC_DIR_T16_TSS16; // RQ5
              end
            end
            jump_timing_pkg::TGT_TSS32: begin
              add_m_c = 1'b0;
              if (task_is_32) begin
                base_c = jump_timing_pkg::CYC_DIR_T32_TSS32; // RQ6
              end else begin
                base_c = jump_timing_pkg::CYC_DIR_T16_TSS32; // RQ5
              end
            end
            jump_timing_pkg::TGT_V86_TASK: begin
              add_m_c = 1'b0;
              if (task_is_32) begin
                base_c = jump_timing_pkg::CYC_DIR_T32_V86; // RQ6
              end else begin
                base_c = jump_timing_pkg::CYC_DIR_T16_V86; // RQ5
              end
            end
            // unused target codes 5..7 fall back to a plain segment
            default: base_c = jump_timing_pkg::CYC_FAR_DIR_PROT;
          endcase
        end
      end
      jump_timing_pkg::FORM_FAR_IND: begin
        // real-mode timing for this form is not given; the protected figure stands in
        // 32-bit task switches borrow the direct-form totals
        unique case (tk)
          jump_timing_pkg::TGT_CALL_GATE: base_c = jump_timing_pkg::CYC_GATE_IND; // RQ4
          jump_timing_pkg::TGT_TSS16: begin
            add_m_c = 1'b0;
            if (task_is_32) begin
              base_c = jump_timing_pkg::CYC_DIR_T32_TSS16;
            end else begin
              base_c = jump_timing_pkg::CYC_IND_T16_TSS16; // RQ7
            end
          end
          jump_timing_pkg::TGT_TSS32: begin
            add_m_c = 1'b0;
            if (task_is_32) begin
              base_c = jump_timing_pkg::CYC_DIR_T32_TSS32;
            end else begin
              base_c = jump_timing_pkg::CYC_IND_T16_TSS32; // RQ7
            end
          end
          jump_timing_pkg::TGT_V86_TASK: begin
            add_m_c = 1'b0;
            if (task_is_32) begin
              base_c = jump_timing_pkg::CYC_DIR_T32_V86;
            end else begin
              base_c = jump_timing_pkg::CYC_IND_T16_V86; // RQ7
            end
          end
          default: base_c = jump_timing_pkg::CYC_FAR_IND_PROT; // RQ3
        endcase
      end
      default: begin
        base_c  = jump_timing_pkg::CYC_COUNT_RESET;
        add_m_c = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // result registers
  // ****************************************************************
  logic       accept;
  logic [8:0] total_c;
  logic       is_jump_r;
  logic       is_jump_nxt;
  logic [2:0] form_r;
  logic [2:0] form_nxt;
  logic [8:0] count_r;
  logic [8:0] count_nxt;

  jump_cycle_if cyc ();

  // task switches are fixed totals; other forms add m
  assign total_c = base_c + (add_m_c ? {5'h0_0, next_components} : 9'h0_000); // RQ8
  // one jump at a time: hold off new decode while a count runs
  assign instr_ready = !cyc.busy;
  assign accept      = instr_valid && instr_ready && (form_c != jump_timing_pkg::FORM_NONE);

  always_comb begin
    is_jump_nxt = is_jump_r;
    form_nxt    = form_r;
    count_nxt   = count_r;
    if (instr_valid && instr_ready) begin
      is_jump_nxt = (form_c != jump_timing_pkg::FORM_NONE);
      form_nxt    = form_c;
      count_nxt   = total_c;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      is_jump_r <= 1'b0;
      form_r    <= jump_timing_pkg::FORM_NONE;
      count_r   <= jump_timing_pkg::CYC_COUNT_RESET;
    end else if (clk_en) begin
      is_jump_r <= is_jump_nxt;
      form_r    <= form_nxt;
      count_r   <= count_nxt;
    end
  end

  // ****************************************************************
  // counter hand-off
  // ****************************************************************
  assign cyc.load   = accept;
  assign cyc.budget = total_c;

  jump_cycle_counter u_counter (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .cyc     (cyc.counter)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign is_jump     = is_jump_r;
  assign jump_form   = form_r;
  assign cycle_count = count_r;
  assign busy        = cyc.busy;
  assign done        = cyc.done;

endmodule
`default_nettype wire

// ==== test/jump_timing_assertions.sv ====
// checker: jump decode forms and cycle counts at the decoder ports
`timescale 1ns/10ps
`default_nettype none
module jump_timing_assertions (
  // clock, reset, enable
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       clk_en,
  // decode request
  input wire logic       instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] modrm,
  input wire logic       prot_mode,
  input wire logic       v86_mode,
  input wire logic       task_is_32,
  input wire logic [2:0] target_kind,
  input wire logic [3:0] next_components,
  // decode result
  input wire logic       instr_ready,
  input wire logic       is_jump,
  input wire logic [2:0] jump_form,
  input wire logic [8:0] cycle_count,
  input wire logic       busy,
  input wire logic       done
);
  logic       tk;
  logic       fd;
  logic       fi;
  logic       pm;
  logic       ts;
  logic [8:0] m9;
  logic [8:0] run_r;
  logic [8:0] run_nxt;
  assign tk = clk_en & instr_valid & instr_ready;
  assign fd = tk & (opcode == 8'hea);
  assign fi = tk & (opcode == 8'hff) & (modrm[5:3] == 3'h5);
  assign pm = prot_mode & ~v86_mode;
  assign ts = pm & (target_kind inside {3'h2, 3'h3, 3'h4});
  assign m9 = {5'h00, next_components};
  // enabled cycles since the last take; frozen edges must not count
  always_comb begin
    run_nxt = (busy && clk_en) ? run_r + 9'h001 : run_r;
    if (tk || !nrst) begin
      run_nxt = {8'h00, nrst};
    end
  end
  always_ff @(posedge clk_sys) begin
    run_r <= run_nxt;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_NEAR: assert property (tk && opcode == 8'hff && modrm[5:3] == 3'h4 |=> is_jump &&
    cycle_count == ($past(modrm[7:6]) == 2'h3 ? 9'h007 : 9'h00a) + $past(m9)) else $error("near");
  AST_DIR_REAL: assert property (fd && !pm |=>
    jump_form == 3'h3 && cycle_count == 9'h00c + $past(m9)) else $error("far real");
  AST_DIR_PROT: assert property (fd && pm && target_kind == 3'h0 |=>
    cycle_count == 9'h01b + $past(m9)) else $error("far prot");
  AST_IND_PROT: assert property (fi && pm && target_kind == 3'h0 |=>
    jump_form == 3'h4 && cycle_count == 9'h01f + $past(m9)) else $error("far ind");
  AST_GATE: assert property ((fd || fi) && pm && target_kind == 3'h1 |=>
    cycle_count == ($past(fd) ? 9'h02d : 9'h031) + $past(m9)) else $error("gate");
  AST_T16_DIR: assert property (fd && ts && !task_is_32 |=> cycle_count ==
    ($past(target_kind) == 3'h2 ? 9'h112 : $past(target_kind) == 3'h3 ? 9'h12d : 9'h0db))
    else $error("switch from 16-bit task, direct");
  AST_T32_DIR: assert property (fd && ts && task_is_32 |=> cycle_count ==
    ($past(target_kind) == 3'h2 ? 9'h10e : $past(target_kind) == 3'h3 ? 9'h12f : 9'h0dd))
    else $error("switch from 32-bit task, direct");
  AST_T16_IND: assert property (fi && ts && !task_is_32 |=> cycle_count ==
    ($past(target_kind) == 3'h2 ? 9'h117 : $past(target_kind) == 3'h3 ? 9'h132 : 9'h0df))
    else $error("switch from 16-bit task, indirect");
  AST_DONE_AT: assert property (done |-> busy && run_r == cycle_count)
    else $error("done early or late");
endmodule
bind jump_decode_cycle_timing jump_timing_assertions chk (.clk_sys, .nrst, .clk_en,
  .instr_valid, .opcode, .modrm, .prot_mode, .v86_mode, .task_is_32, .target_kind,
  .next_components, .instr_ready, .is_jump, .jump_form, .cycle_count, .busy, .done);
`default_nettype wire

// ==== test/tb.sv ====
// testbench: jump forms, cycle counts, refusal, freeze and reset
`timescale 1ns/10ps
`default_nettype none
module tb;
  // mode bits: protected, virtual-8086, 32-bit task
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] mrm;
    logic [2:0] mode;
    logic [2:0] tgt;
    logic [3:0] m;
    logic [2:0] form;
    logic [8:0] cnt;
  } row_t;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic       clk_en = 1'b1;
  logic       instr_valid = 1'b0;
  row_t       cur = '0;
  logic       instr_ready;
  logic       is_jump;
  logic [2:0] jump_form;
  logic [8:0] cycle_count;
  logic       busy;
  logic       done;
  int         bad_count = 0;
  int         n_compared = 0;
  int         n;
  row_t       rows [17] = '{
    '{8'hff, 8'he0, 3'h0, 3'h0, 4'h2, 3'h1, 9'h009}, '{8'hff, 8'h26, 3'h0, 3'h0, 4'h0, 3'h2, 9'h00a},
    '{8'hea, 8'h00, 3'h0, 3'h0, 4'h3, 3'h3, 9'h00f}, '{8'hea, 8'h00, 3'h6, 3'h0, 4'h1, 3'h3, 9'h00d},
    '{8'hea, 8'h00, 3'h4, 3'h0, 4'hf, 3'h3, 9'h02a}, '{8'hea, 8'h00, 3'h4, 3'h1, 4'h1, 3'h3, 9'h02e},
    '{8'hff, 8'h2e, 3'h4, 3'h0, 4'h2, 3'h4, 9'h021}, '{8'hff, 8'h2e, 3'h4, 3'h1, 4'h0, 3'h4, 9'h031},
    '{8'hea, 8'h00, 3'h4, 3'h2, 4'h5, 3'h3, 9'h112}, '{8'hea, 8'h00, 3'h4, 3'h3, 4'h0, 3'h3, 9'h12d},
    '{8'hea, 8'h00, 3'h4, 3'h4, 4'h0, 3'h3, 9'h0db}, '{8'hea, 8'h00, 3'h5, 3'h2, 4'h0, 3'h3, 9'h10e},
    '{8'hea, 8'h00, 3'h5, 3'h3, 4'h0, 3'h3, 9'h12f}, '{8'hea, 8'h00, 3'h5, 3'h4, 4'h0, 3'h3, 9'h0dd},
    '{8'hff, 8'h2e, 3'h4, 3'h2, 4'h0, 3'h4, 9'h117}, '{8'hff, 8'h2e, 3'h4, 3'h3, 4'h0, 3'h4, 9'h132},
    '{8'hff, 8'h2e, 3'h4, 3'h4, 4'h0, 3'h4, 9'h0df}};
  always #2 clk_sys = ~clk_sys;
  jump_decode_cycle_timing dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .instr_valid(instr_valid), .opcode(cur.op), .modrm(cur.mrm), .prot_mode(cur.mode[2]),
    .v86_mode(cur.mode[1]), .task_is_32(cur.mode[0]), .target_kind(cur.tgt),
    .next_components(cur.m), .instr_ready(instr_ready), .is_jump(is_jump),
    .jump_form(jump_form), .cycle_count(cycle_count), .busy(busy), .done(done));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // present at a falling edge; it is taken at the next rising edge
  task automatic present(input row_t r);
    cur = r;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
  endtask
  // n is the enabled cycle index after the take in which done shows
  task automatic wait_done();
    n = 1;
    while (done !== 1'b1) begin
      @(negedge clk_sys);
      n = clk_en ? n + 1 : n;
      if (n > 400) begin
        bad_count++;
        $display("BAD %0t done never came", $time);
        end_of_test();
      end
    end
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    chk({2'h0, instr_ready, is_jump, jump_form, busy, done}, 9'h040);
    nrst = 1'b1;
    foreach (rows[i]) begin
      present(rows[i]);
      chk({5'h00, is_jump, jump_form}, {6'h01, rows[i].form});
      chk(cycle_count, rows[i].cnt);
      wait_done();
      chk(9'(n), rows[i].cnt);
      @(negedge clk_sys);
      chk({7'h00, busy, instr_ready}, 9'h001);
      $display("row %0d ended", i);
    end
    // a request while busy must be refused; frozen cycles must not count
    present(rows[1]);
    cur = rows[0];
    instr_valid = 1'b1;
    clk_en = 1'b0;
    repeat (3) @(negedge clk_sys);
    clk_en = 1'b1;
    wait_done();
    instr_valid = 1'b0;
    chk(9'(n), 9'h00a);
    chk({5'h00, is_jump, jump_form}, 9'h00a);
    @(negedge clk_sys);
    $display("refusal and freeze ended");
    present('{8'h90, 8'h00, 3'h4, 3'h0, 4'h0, 3'h0, 9'h000});
    chk({4'h0, is_jump, jump_form, busy}, 9'h000);
    present('{8'hff, 8'h10, 3'h4, 3'h0, 4'h0, 3'h0, 9'h000});
    chk({4'h0, is_jump, jump_form, busy}, 9'h000);
    $display("non-jump ended");
    present(rows[14]);
    repeat (20) @(negedge clk_sys);
    nrst = 1'b0;
    @(negedge clk_sys);
    chk({2'h0, instr_ready, is_jump, jump_form, busy, done}, 9'h040);
    chk(cycle_count, 9'h000);
    nrst = 1'b1;
    present(rows[0]);
    wait_done();
    chk(9'(n), 9'h009);
    $display("mid-run reset ended");
    end_of_test();
  end
endmodule
`default_nettype wire
